// ### logic/lrac_pkg.sv
/*
  Shared constants for the text-display address and RAM access command block:
  register offsets, status and config fields, text RAM line ranges and
  execution times. Assumes a single 40 MHz clock.
*/
package lrac_pkg;

  // clock and execution times
  localparam int CLK_MHZ      = 40;
  localparam int EXEC_TIME_NS = 39000;    // 39 us, short instructions and data
  localparam int LONG_TIME_NS = 1530000;  // 1.53 ms, clear and return home
  localparam int EXEC_CYCLES  = (EXEC_TIME_NS * CLK_MHZ) / 1000;
  localparam int LONG_CYCLES  = (LONG_TIME_NS * CLK_MHZ) / 1000;

  // register offsets, byte addresses
  localparam logic [3:0] OFS_CMD    = 4'h0;
  localparam logic [3:0] OFS_DATA   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CONFIG = 4'hC;

  // status word fields
  localparam int ST_BUSY_BIT   = 7;
  localparam int ST_SCROLL_LSB = 8;
  localparam int ST_TARGET_LSB = 14;
  localparam int ST_SHIFT_LSB  = 16;

  // config word fields and reset value
  localparam int         CFG_INC_BIT  = 0;
  localparam int         CFG_TWO_BIT  = 1;
  localparam int         CFG_FOUR_BIT = 2;
  localparam int         CFG_EXT_BIT  = 3;
  localparam logic [3:0] CFG_RESET    = 4'h1;

  // text RAM layout and fill code
  localparam logic [7:0] BLANK_CODE   = 8'h20;
  localparam logic [6:0] HOME_ADDR    = 7'h00;
  localparam logic [6:0] LINE1_LAST   = 7'h4F;
  localparam logic [6:0] LINE2A_LAST  = 7'h27;
  localparam logic [6:0] LINE2B_FIRST = 7'h40;
  localparam logic [6:0] LINE2B_LAST  = 7'h67;
  localparam logic [4:0] LINE4_LAST   = 5'h13;
  localparam logic [5:0] SCROLL_FULL  = 6'h30;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TGT_TEXT, TGT_GLYPH, TGT_ICON} lrac_target_t;

endpackage : lrac_pkg

// ### logic/lrac_ram.sv
/*
  Simple dual-port RAM with registered read data.
  Assumes one clock; read data appear one edge after the address.
*/
module lrac_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // storage, no reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : lrac_ram

// ### logic/lrac_top.sv
/*
  Instruction interpreter for a character display controller: address set
  commands, scroll quantity, busy and address read, RAM data access with
  auto stepping and a one-word read prefetch, clear and return home.
  Assumes an AXI4-Lite master on clk; one write and one read at a time.
*/
// Operation
// - normal mode, 01xxxxxx loads six bits into counter, targets glyph RAM.
// - extended mode, 01xxxxxx loads low four bits, targets icon RAM.
// - normal mode, 1xxxxxxx loads seven bits into counter, targets text RAM.
// - one-line mode text addresses run 00h to 4Fh.
// - two-line mode lines run 00h-27h and 40h-67h.
// - four-line mode lines run 00h-13h, 20h-33h, 40h-53h, 60h-73h.
// - extended mode, 1xxxxxxx loads six-bit scroll quantity, zero means no shift.
// - scroll quantity with top bits 11 shifts by 48 dots.
// - status read gives busy on bit 7 and counter on bits 6-0.
// - data write stores byte in the selected RAM at the counter, text RAM only at displayed addresses.
// - counter steps by one after each data write.
// - data read returns a byte from the selected RAM.
// - reads come from a prefetch register loaded by address set.
// - cursor shift with text RAM selected also reloads the prefetch register.
// - counter steps by one after each data read taken while idle with no command or data write in the same cycle.
// - clear fills text RAM with 20h, zeroes counter, takes 1.53 ms.
// - return home zeroes counter and display shift, keeps text RAM.
// - entry direction bit set increments, cleared decrements.
// - extended select bit chooses the meaning of shared opcodes.
module lrac_top
  import lrac_pkg::*;
#(
  parameter int AXI_AW      = 4,
  parameter int LONG_CNT    = LONG_CYCLES,
  parameter int EXEC_CNT    = EXEC_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write channels
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // display side state
  output logic                   busy_flag,
  output logic [5:0]             scroll_shift
);

  // busy must last at least eight cycles, the hold that a_busy_after_go checks
  if (AXI_AW < 4 || LONG_CNT < 130 || LONG_CNT > 65535 || EXEC_CNT < 8
      || EXEC_CNT > LONG_CNT) begin : g_bad_param
    $error("lrac_top: unsupported parameter values");
  end

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_LOAD, S_CLEAR, S_WAIT} lrac_state_t;

  // step the counter inside the selected RAM, following text line ranges
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input lrac_target_t t, input logic two,
                                           input logic four);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (t == TGT_GLYPH) r = {1'b0, r[5:0]};
    else if (t == TGT_ICON) r = {3'h0, r[3:0]};
    else if (four) begin
      if (up && a[4:0] == LINE4_LAST) r = {a[6:5] + 2'h1, 5'h00};
      else if (!up && a[4:0] == 5'h00) r = {a[6:5] - 2'h1, LINE4_LAST};
    end else if (two) begin
      if (up && a == LINE2A_LAST) r = LINE2B_FIRST;
      else if (up && a == LINE2B_LAST) r = HOME_ADDR;
      else if (!up && a == HOME_ADDR) r = LINE2B_LAST;
      else if (!up && a == LINE2B_FIRST) r = LINE2A_LAST;
    end else begin
      if (up && a == LINE1_LAST) r = HOME_ADDR;
      else if (!up && a == HOME_ADDR) r = LINE1_LAST;
    end
    return r;
  endfunction : step_addr

  // true where a text address belongs to a displayed line
  function automatic logic text_valid(input logic [6:0] a, input logic two,
                                      input logic four);
    if (four) return a[4:0] <= LINE4_LAST;
    if (two) return a <= LINE2A_LAST || (a >= LINE2B_FIRST && a <= LINE2B_LAST);
    return a <= LINE1_LAST;
  endfunction : text_valid

  // state
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic              wstrb0_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;
  logic [6:0]        ac_reg, ac_next, clr_reg;
  lrac_target_t      target_reg, target_next;
  logic              inc_reg, two_reg, four_reg, ext_reg;
  logic [5:0]        scroll_reg, scroll_out_reg;
  logic [7:0]        dshift_reg, dshift_next, out_reg;
  lrac_state_t       state_reg, state_next;
  logic [15:0]       cnt_reg;
  logic              busy_reg;
  logic [7:0]        text_rd, glyph_rd, icon_rd, sel_rd;

  // write channels take address and data in either order, answer after both
  wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
  wire do_read  = s_axi_arvalid && arready_reg;
  wire [3:0] wofs = awaddr_reg[3:0];
  wire [3:0] rofs = s_axi_araddr[3:0];
  wire wr_hit = (wofs == OFS_CMD) || (wofs == OFS_DATA) || (wofs == OFS_STATUS)
                || (wofs == OFS_CONFIG);
  wire rd_hit = (rofs == OFS_CMD) || (rofs == OFS_DATA) || (rofs == OFS_STATUS)
                || (rofs == OFS_CONFIG);
  wire upper_zero_w = (awaddr_reg >> 4) == '0;
  wire upper_zero_r = (s_axi_araddr >> 4) == '0;

  // accepted operations; commands and data sent while busy are dropped, config writes are still taken
  wire idle      = (state_reg == S_IDLE);
  wire cmd_go    = do_write && upper_zero_w && wofs == OFS_CMD && wstrb0_reg && idle;
  wire dwr_go    = do_write && upper_zero_w && wofs == OFS_DATA && wstrb0_reg && idle;
  wire drd_go    = do_read && upper_zero_r && rofs == OFS_DATA && idle && !cmd_go
                   && !dwr_go;
  wire cfg_wr    = do_write && upper_zero_w && wofs == OFS_CONFIG && wstrb0_reg;
  wire any_go    = cmd_go || dwr_go || drd_go;

  // command decode, extended select splits shared opcodes
  wire [7:0] c       = wdata_reg[7:0];
  wire is_clear      = cmd_go && c == 8'h01;
  wire is_home       = cmd_go && c[7:1] == 7'h01;
  wire is_entry      = cmd_go && c[7:2] == 6'h01;
  wire is_shift      = cmd_go && c[7:4] == 4'h1 && !ext_reg;
  wire is_cursor     = is_shift && !c[3];
  wire is_func       = cmd_go && c[7:5] == 3'h1;
  wire is_extfn      = cmd_go && c[7:3] == 5'h01 && ext_reg;
  wire is_glyph      = cmd_go && c[7:6] == 2'h1 && !ext_reg;
  wire is_icon       = cmd_go && c[7:6] == 2'h1 && ext_reg;
  wire is_text       = cmd_go && c[7] && !ext_reg;
  wire is_scroll     = cmd_go && c[7] && ext_reg;
  wire fetch         = is_glyph || is_icon || is_text || drd_go
                       || (is_cursor && target_reg == TGT_TEXT);

  // address counter next value
  assign ac_next =
    (is_clear || is_home) ? HOME_ADDR :
    is_glyph  ? {1'b0, c[5:0]} :
    is_icon   ? {3'h0, c[3:0]} :
    is_text   ? c[6:0] :
    is_cursor ? step_addr(ac_reg, c[2], TGT_TEXT, two_reg, four_reg) :
    (dwr_go || drd_go) ?
      step_addr(ac_reg, inc_reg, target_reg, two_reg, four_reg) :
    ac_reg;

  assign target_next = is_glyph ? TGT_GLYPH : is_icon ? TGT_ICON :
                       (is_text || is_clear || is_home) ? TGT_TEXT : target_reg;

  // display shift position; home undoes it
  assign dshift_next = is_home ? 8'h00 :
                       (is_shift && c[3] && c[2]) ? dshift_reg + 8'h01 :
                       (is_shift && c[3]) ? dshift_reg - 8'h01 : dshift_reg;

  // sequencer: prefetch, clear fill, execution wait
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:  if (any_go) state_next = is_clear ? S_CLEAR : fetch ? S_FETCH : S_WAIT;
      S_FETCH: state_next = S_LOAD;
      S_LOAD:  state_next = S_WAIT;
      S_CLEAR: if (clr_reg == 7'h7F) state_next = S_WAIT;
      S_WAIT:  if (cnt_reg == 16'h0000) state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 16'h0000;
      clr_reg   <= 7'h00;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next != S_IDLE);
      if (any_go) begin
        cnt_reg <= (is_clear || is_home) ? 16'(LONG_CNT - 1) : 16'(EXEC_CNT - 1);
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      clr_reg <= (state_reg == S_CLEAR) ? clr_reg + 7'h01 : 7'h00;
    end
  end

  // instruction-visible registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ac_reg     <= HOME_ADDR;
      target_reg <= TGT_TEXT;
      {ext_reg, four_reg, two_reg, inc_reg} <= CFG_RESET;
      scroll_reg <= 6'h00;
      dshift_reg <= 8'h00;
    end else begin
      ac_reg     <= ac_next;
      target_reg <= target_next;
      dshift_reg <= dshift_next;
      if (is_scroll) scroll_reg <= c[5:0];
      if (cfg_wr) begin
        inc_reg  <= wdata_reg[CFG_INC_BIT];
        two_reg  <= wdata_reg[CFG_TWO_BIT];
        four_reg <= wdata_reg[CFG_FOUR_BIT];
        ext_reg  <= wdata_reg[CFG_EXT_BIT];
      end else begin
        if (is_entry) inc_reg <= c[1];
        if (is_func) begin
          two_reg <= c[3];
          ext_reg <= c[2];
        end
        if (is_extfn) four_reg <= c[0];
      end
    end
  end

  // the three RAMs; text data writes only land on displayed addresses, clear fills all 128
  wire clearing = (state_reg == S_CLEAR);
  wire text_we  = clearing ||
                  (dwr_go && target_reg == TGT_TEXT
                   && text_valid(ac_reg, two_reg, four_reg));
  wire glyph_we = dwr_go && target_reg == TGT_GLYPH;
  wire icon_we  = dwr_go && target_reg == TGT_ICON;

  lrac_ram #(.AW(7), .DW(8)) u_text_ram (
    .clk   (clk),
    .we    (text_we),
    .waddr (clearing ? clr_reg : ac_reg),
    .wdata (clearing ? BLANK_CODE : c),
    .raddr (ac_reg),
    .rdata (text_rd)
  );

  lrac_ram #(.AW(6), .DW(8)) u_glyph_ram (
    .clk   (clk),
    .we    (glyph_we),
    .waddr (ac_reg[5:0]),
    .wdata (c),
    .raddr (ac_reg[5:0]),
    .rdata (glyph_rd)
  );

  lrac_ram #(.AW(4), .DW(8)) u_icon_ram (
    .clk   (clk),
    .we    (icon_we),
    .waddr (ac_reg[3:0]),
    .wdata (c),
    .raddr (ac_reg[3:0]),
    .rdata (icon_rd)
  );

  assign sel_rd = (target_reg == TGT_GLYPH) ? glyph_rd :
                  (target_reg == TGT_ICON) ? icon_rd : text_rd;

  // prefetch register; writes leave it stale on purpose
  always_ff @(posedge clk) begin
    if (rst) out_reg <= 8'h00;
    else if (state_reg == S_LOAD) out_reg <= sel_rd;
  end

  // 48-dot cap when both top scroll bits are set
  wire [5:0] scroll_eff = (scroll_reg[5:4] == 2'h3) ? SCROLL_FULL : scroll_reg;

  // read word select
  wire [31:0] status_word = {8'h00, dshift_reg, target_reg, scroll_eff,
                             busy_reg, ac_reg};
  wire [31:0] config_word = {28'h0000000, ext_reg, four_reg, two_reg, inc_reg};
  wire [31:0] rd_word = (rofs == OFS_DATA) ? {24'h000000, out_reg} :
                        (rofs == OFS_STATUS) ? status_word :
                        (rofs == OFS_CONFIG) ? config_word : 32'h00000000;

  // axi write channel handshakes
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awaddr_reg  <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_hit && upper_zero_w) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // axi read channel; answer one edge after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else if (do_read) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= (rd_hit && upper_zero_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // display side outputs
  always_ff @(posedge clk) begin
    if (rst) scroll_out_reg <= 6'h00;
    else scroll_out_reg <= scroll_eff;
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign busy_flag     = busy_reg;
  assign scroll_shift  = scroll_out_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_glyph_addr_load: assert property (is_glyph |=> ac_reg == {1'b0, $past(c[5:0])}
    && target_reg == TGT_GLYPH) else $error("glyph address load wrong");
  a_icon_addr_load: assert property (is_icon |=> ac_reg == {3'h0, $past(c[3:0])}
    && target_reg == TGT_ICON) else $error("icon address load wrong");
  a_text_addr_load: assert property (is_text |=> ac_reg == $past(c[6:0])
    && target_reg == TGT_TEXT) else $error("text address load wrong");
  a_two_line_wrap: assert property (dwr_go && target_reg == TGT_TEXT && inc_reg
    && two_reg && !four_reg && ac_reg == LINE2A_LAST |=> ac_reg == LINE2B_FIRST)
    else $error("two-line wrap wrong");
  a_four_line_wrap: assert property (dwr_go && target_reg == TGT_TEXT && inc_reg
    && four_reg && ac_reg == 7'h13 |=> ac_reg == 7'h20)
    else $error("four-line wrap wrong");
  a_scroll_full_cap: assert property (is_scroll && c[5:4] == 2'h3 |=> ##1
    scroll_shift == SCROLL_FULL) else $error("scroll cap wrong");
  a_status_word_read: assert property (do_read && rofs == OFS_STATUS |=>
    s_axi_rdata[7:0] == {$past(busy_reg), $past(ac_reg)}) else $error("status bad");
  a_data_read_prefetch: assert property (do_read && rofs == OFS_DATA |=>
    s_axi_rdata[7:0] == $past(out_reg)) else $error("read not from prefetch");
  a_busy_after_go: assert property (any_go |=> busy_flag [*8])
    else $error("busy not held");
  a_home_zeroes: assert property (is_home |=> ac_reg == HOME_ADDR && dshift_reg == 8'h00
    && busy_flag) else $error("home wrong");
  a_clear_fill_start: assert property (is_clear |=> ac_reg == HOME_ADDR
    && state_reg == S_CLEAR ##1 text_we) else $error("clear wrong");

  c_clear_done: cover property (state_reg == S_CLEAR ##1 state_reg == S_WAIT);
  c_read_after_set: cover property (is_text ##[1:1000] drd_go);
  c_icon_write: cover property (is_icon ##[1:1000] icon_we);

endmodule : lrac_top

// ### bench/lrac_host.sv
/*
  Host bus master model: drives the AXI4-Lite port of lrac_top.
  Assumes one clock; the slave answers in its own time, bounded here.
*/
module lrac_host (
  // clock and busy level
  input  wire logic        clk,
  input  wire logic        busy_flag,
  // write side
  output logic [4:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  output logic             bready,
  input  wire logic        bvalid,
  // read side
  output logic [4:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  output logic             rready,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // both halves offered at once, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output bit ok);
    ok = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        ok = 1;
      end
    end
  endtask : wr

  // rready held until the answer is sampled
  task automatic rd(input logic [4:0] a, output bit ok);
    ok = 0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        ok = 1;
      end
    end
  endtask : rd

  // no new instruction until busy clears
  task automatic idle(output int n);
    for (n = 0; n < 300 && busy_flag; n++) @(posedge clk);
  endtask : idle
endmodule : lrac_host

// ### bench/lrac_top_tb.sv
/*
  Self-checking bench for lrac_top: reads queue their expectations,
  a monitor compares each read answer. Assumes shortened busy counts.
*/
module lrac_top_tb
  import lrac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] A_CMD = 5'h00;
  localparam logic [4:0] A_DAT = 5'h04;
  localparam logic [4:0] A_ST  = 5'h08;
  localparam logic [4:0] A_CFG = 5'h0C;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, busy_flag;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [5:0]  scroll_shift;
  logic [7:0]  d0, d1;
  logic [31:0] exp_q[$], mask_q[$], lfsr_st;
  logic [1:0]  resp_q[$];
  int          fail_count, tests_run, n;

  lrac_top #(.AXI_AW(5), .LONG_CNT(200), .EXEC_CNT(8)) DUT (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .busy_flag(busy_flag), .scroll_shift(scroll_shift));

  lrac_host host (
    .clk(clk), .busy_flag(busy_flag), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bready(bready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rready(rready), .rvalid(rvalid));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    $display("counts: compares=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // oldest note is matched against each read answer
  always @(posedge clk) begin
    if (rvalid && rready && exp_q.size() > 0) begin
      check(rdata & mask_q.pop_front(), exp_q.pop_front());
      check({30'h0, rresp}, {30'h0, resp_q.pop_front()});
    end
    // every bench write goes to a mapped offset, so each answer is OKAY
    if (bvalid && bready) begin
      check({30'h0, bresp}, {30'h0, RESP_OKAY});
    end
  end

  // write, then wait out busy unless asked not to
  task automatic wreg(input logic [4:0] a, input logic [7:0] d, input bit w = 1);
    bit ok;
    host.wr(a, {24'h0, d}, ok);
    if (w) host.idle(n);
    if (!ok || n >= 300) begin
      fail_count++;
      give_verdict();
    end
  endtask : wreg

  task automatic rreg(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] r = RESP_OKAY);
    bit ok;
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    resp_q.push_back(r);
    host.rd(a, ok);
    // a data read starts an operation too; wait it out before the next one
    host.idle(n);
    if (!ok || n >= 300) begin
      fail_count++;
      give_verdict();
    end
  endtask : rreg

  task automatic st(input logic [6:0] ac, input logic [1:0] tgt);
    rreg(A_ST, {16'h0, tgt, 7'h0, ac}, 32'h0000_C0FF);
  endtask : st

  task automatic rdat(input logic [7:0] e);
    rreg(A_DAT, {24'h0, e}, 32'h0000_00FF);
  endtask : rdat

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic rnd(output logic [7:0] d);
    lfsr_st = lfsr_next(lfsr_st);
    d = lfsr_st[7:0];
  endtask : rnd

  // main sequence; range tables: config, start address, address after write
  initial begin
    automatic logic [3:0] cf[5] = '{4'h1, 4'h3, 4'h3, 4'h7, 4'h7};
    automatic logic [6:0] sa[5] = '{7'h4F, 7'h27, 7'h67, 7'h13, 7'h73};
    automatic logic [6:0] na[5] = '{7'h00, 7'h40, 7'h00, 7'h20, 7'h00};
    automatic logic [7:0] sq[3] = '{8'hAF, 8'hF5, 8'h80};
    automatic logic [5:0] sv[3] = '{6'h2F, 6'h30, 6'h00};
    rst = 1'b1;
    lfsr_st = 32'h7E5F6DF9;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({26'h0, scroll_shift}, 32'h0);
    st(7'h00, TGT_TEXT);
    wreg(A_CMD, 8'h01, 0);
    check({31'h0, busy_flag}, 32'h1);
    host.idle(n);
    check(n inside {[190:210]}, 32'h1);
    st(7'h00, TGT_TEXT);
    wreg(A_CMD, 8'h85);
    rdat(8'h20);
    rdat(8'h20);
    $display("test clear done");
    rnd(d0);
    rnd(d1);
    wreg(A_CMD, 8'h80);
    wreg(A_DAT, d0);
    wreg(A_DAT, d1);
    st(7'h02, TGT_TEXT);
    wreg(A_CMD, 8'h80);
    rdat(d0);
    rdat(d1);
    wreg(A_CMD, 8'h80);
    rdat(d0);
    wreg(A_CMD, 8'h10);
    rdat(d0);
    $display("test text access done");
    wreg(A_CFG, 8'h00);
    wreg(A_CMD, 8'h85);
    wreg(A_DAT, 8'h11);
    st(7'h04, TGT_TEXT);
    wreg(A_CMD, 8'h85);
    rdat(8'h11);
    st(7'h04, TGT_TEXT);
    wreg(A_CFG, 8'h01);
    wreg(A_CMD, 8'h7F);
    st(7'h3F, TGT_GLYPH);
    wreg(A_DAT, 8'h77);
    st(7'h00, TGT_GLYPH);
    wreg(A_CMD, 8'h7F);
    rdat(8'h77);
    $display("test direction and glyph done");
    wreg(A_CFG, 8'h09);
    wreg(A_CMD, 8'h7A);
    st(7'h0A, TGT_ICON);
    wreg(A_DAT, 8'h3C);
    wreg(A_CMD, 8'h7A);
    rdat(8'h3C);
    for (int i = 0; i < 3; i++) begin
      wreg(A_CMD, sq[i]);
      check({26'h0, scroll_shift}, {26'h0, sv[i]});
      rreg(A_ST, {18'h0, sv[i], 8'h0}, 32'h0000_3F00);
    end
    wreg(A_CFG, 8'h01);
    $display("test extended done");
    for (int i = 0; i < 5; i++) begin
      rnd(d0);
      wreg(A_CFG, {4'h0, cf[i]});
      wreg(A_CMD, {1'b1, sa[i]});
      wreg(A_DAT, d0);
      st(na[i], TGT_TEXT);
    end
    wreg(A_CFG, 8'h01);
    $display("test line ranges done");
    wreg(A_CMD, 8'h85);
    wreg(A_CMD, 8'h02);
    st(7'h00, TGT_TEXT);
    wreg(A_CMD, 8'h81);
    rdat(d1);
    wreg(A_CMD, 8'h85, 0);
    rreg(A_ST, 32'h85, 32'hFF);
    host.idle(n);
    rreg(5'h10, 32'h0, 32'h0, RESP_SLVERR);
    $display("test home and status done");
    give_verdict();
  end
endmodule : lrac_top_tb
